// [design/cmb_channel_mode_ctl.v]
`timescale 1ns/1ps
`include "cmb_channel_mode_map.vh"

module cmb_channel_mode_ctl (
  input wire mclk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [3:0] host_byte_valid,
  input wire [31:0] host_byte_data,
  output wire [3:0] host_byte_ready,
  output wire [3:0] sample_valid,
  output wire [31:0] sample_data,
  input wire [3:0] sample_ready,
  input wire [31:0] pin_in,
  output wire [31:0] pin_out,
  output wire [31:0] pin_oe_n,
  output wire [3:0] rs485_tx_enable,
  input wire host_suspend,
  output wire power_enable_n
);

  // ----------------------------------------------------------------
  // local constants
  // ----------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_READ = 3'h1;
  localparam [2:0] ST_DRIVE = 3'h2;
  localparam [2:0] ST_SETUP = 3'h3;
  localparam [2:0] ST_LOW = 3'h4;
  localparam [2:0] ST_HIGH = 3'h5;
  localparam [2:0] ST_WAIT = 3'h6;
  localparam integer SCK_HALF_I = `CMB_SCK_HALF_CYC;
  localparam [7:0] SCK_HALF_M1 = SCK_HALF_I[7:0] - 8'h01;
  // only codes 0, 1, 4 anywhere and 2 on the first two channels count
  function code_ok;
    input [7:0] code;
    input integer ch;
    begin
      code_ok = (code == {5'h00, `CMB_MODE_UART}) ||
                (code == {5'h00, `CMB_MODE_ABB}) ||
                (code == {5'h00, `CMB_MODE_SBB}) ||
                ((code == {5'h00, `CMB_MODE_ENG}) && (ch < `CMB_ENG_CHANNELS));
    end
  endfunction
  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  reg pready_q;
  reg pslverr_q;
  reg [31:0] prdata_q;
  reg [5:0] cfg_q;
  reg [15:0] baud_q;
  reg [31:0] dir_q;
  reg [7:0] sckdiv_q;
  reg pwr_n_q;
  wire [11:0] mode_vec;
  wire [3:0] busy_vec;
  wire [3:0] txen_vec;
  wire access = psel & penable & ~pready_q;
  wire wr_en = psel & penable & pready_q & pwrite & ~pslverr_q;
  wire cmd_wr = wr_en & (paddr == `CMB_OFS_CMD);
  wire [7:0] cmd_code = pwdata[`CMB_CMD_CODE];
  wire [1:0] cmd_chan = pwdata[`CMB_CMD_CHAN];
  reg [31:0] rd_mux;
  reg rd_hit;
  always @*
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `CMB_OFS_CMD: rd_mux = 32'h00000000;
      `CMB_OFS_MODE: rd_mux = {20'h00000, mode_vec};
      `CMB_OFS_CFG: rd_mux = {26'h0000000, cfg_q};
      `CMB_OFS_BAUD: rd_mux = {16'h0000, baud_q};
      `CMB_OFS_DIR: rd_mux = dir_q;
      `CMB_OFS_SCKDIV: rd_mux = {24'h000000, sckdiv_q};
      `CMB_OFS_STATUS: rd_mux = {23'h000000, pwr_n_q, txen_vec, busy_vec};
      default: rd_hit = 1'b0;
    endcase
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else
    begin
      pready_q <= access;
      pslverr_q <= access & ~rd_hit;
      if (access)
        prdata_q <= (pwrite | ~rd_hit) ? 32'h00000000 : rd_mux;
    end
  end

  always @(posedge mclk)
  begin
    if (reset)
    begin
      cfg_q <= `CMB_CFG_RST;
      baud_q <= `CMB_BAUD_RST;
      dir_q <= `CMB_DIR_RST;
      sckdiv_q <= `CMB_SCKDIV_RST;
    end
    else if (wr_en)
    begin
      case (paddr)
        `CMB_OFS_CFG: cfg_q <= pwdata[5:0];
        `CMB_OFS_BAUD: baud_q <= pwdata[15:0];
        `CMB_OFS_DIR: dir_q <= pwdata;
        `CMB_OFS_SCKDIV: sckdiv_q <= pwdata[7:0];
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // power enable and shared baud tick
  // ----------------------------------------------------------------
  reg [15:0] baud_cnt_q;
  reg tick_q;
  wire [15:0] baud_lim = (baud_q == 16'h0000) ? 16'h0000 : baud_q - 16'h0001;
  always @(posedge mclk)
  begin
    if (reset)
    begin
      pwr_n_q <= 1'b1;
      baud_cnt_q <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      pwr_n_q <= host_suspend;
      tick_q <= (baud_cnt_q == baud_lim);
      baud_cnt_q <= (baud_cnt_q == baud_lim) ? 16'h0000 : baud_cnt_q + 16'h0001;
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign power_enable_n = pwr_n_q;

  // ----------------------------------------------------------------
  // per-channel mode logic
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : g_ch
      reg [2:0] mode_q;
      reg [2:0] st_q;
      reg [9:0] sh_q;
      reg [3:0] cnt_q;
      reg busy_q;
      reg pend_q;
      reg [7:0] pend_data_q;
      reg [7:0] pout_q;
      reg [7:0] smp_q;
      reg smp_v_q;
      reg rdy_q;
      reg [7:0] div_q;
      reg txen_q;
      wire [7:0] hbyte = host_byte_data[gi*8 +: 8];
      wire [7:0] pins = pin_in[gi*8 +: 8];
      wire take = host_byte_valid[gi] & rdy_q;
      wire pop = smp_v_q & sample_ready[gi];
      wire mode_chg = cmd_wr && (cmd_chan == gi) && code_ok(cmd_code, gi);
      wire adapt = (gi < `CMB_ENG_CHANNELS) ? cfg_q[4 + (gi % 2)] : 1'b0;
      wire half_done = (div_q == SCK_HALF_M1 + sckdiv_q);
      wire smp_room = ~smp_v_q | pop;
      reg can_take;
      always @*
      begin
        case (mode_q)
          `CMB_MODE_UART: can_take = ~busy_q;
          `CMB_MODE_ABB: can_take = ~pend_q;
          `CMB_MODE_SBB: can_take = (st_q == ST_IDLE) & smp_room;
          `CMB_MODE_ENG: can_take = (st_q == ST_IDLE) & smp_room;
          default: can_take = 1'b0;
        endcase
      end

      always @(posedge mclk)
      begin
        if (reset)
        begin
          mode_q <= `CMB_MODE_UART;
          st_q <= ST_IDLE;
          sh_q <= 10'h000;
          cnt_q <= 4'h0;
          busy_q <= 1'b0;
          pend_q <= 1'b0;
          pend_data_q <= 8'h00;
          pout_q <= `CMB_PINS_IDLE;
          smp_q <= 8'h00;
          smp_v_q <= 1'b0;
          rdy_q <= 1'b0;
          div_q <= 8'h00;
          txen_q <= 1'b0;
        end
        else if (mode_chg)
        begin
          // only this channel is touched; others keep running
          mode_q <= cmd_code[2:0];
          st_q <= ST_IDLE;
          busy_q <= 1'b0;
          pend_q <= 1'b0;
          smp_v_q <= 1'b0;
          rdy_q <= 1'b0;
          txen_q <= 1'b0;
          pout_q <= `CMB_PINS_IDLE;
        end
        else
        begin
          rdy_q <= can_take & ~take;
          if (pop)
            smp_v_q <= 1'b0;
          // rs485 enable bits gate only the uart driver enable
          txen_q <= (mode_q == `CMB_MODE_UART) & busy_q & cfg_q[gi];
          case (mode_q)
            `CMB_MODE_UART:
            begin
              if (take)
              begin
                sh_q <= {1'b1, hbyte, 1'b0};
                cnt_q <= `CMB_UART_BITS;
                busy_q <= 1'b1;
              end
              else if (busy_q & tick_q)
              begin
                if (cnt_q == 4'h0)
                  busy_q <= 1'b0;
                else
                begin
                  pout_q[`CMB_PIN_TXD] <= sh_q[0];
                  sh_q <= {1'b1, sh_q[9:1]};
                  cnt_q <= cnt_q - 4'h1;
                end
              end
            end
            `CMB_MODE_ABB:
            begin
              if (take)
              begin
                pend_q <= 1'b1;
                pend_data_q <= hbyte;
              end
              else if (pend_q & tick_q)
              begin
                pout_q <= pend_data_q;
                pend_q <= 1'b0;
              end
            end
            `CMB_MODE_SBB:
            begin
              // read and write strobes are just these states
              case (st_q)
                ST_IDLE:
                  if (take)
                  begin
                    pend_data_q <= hbyte;
                    st_q <= ST_READ;
                  end
                ST_READ:
                begin
                  smp_q <= pins;
                  smp_v_q <= 1'b1;
                  st_q <= ST_DRIVE;
                end
                ST_DRIVE:
                begin
                  pout_q <= pend_data_q;
                  st_q <= ST_SETUP;
                end
                ST_SETUP: st_q <= ST_IDLE;
                default: st_q <= ST_IDLE;
              endcase
            end
            `CMB_MODE_ENG:
            begin
              case (st_q)
                ST_IDLE:
                  if (take)
                  begin
                    sh_q <= {2'b00, hbyte};
                    cnt_q <= `CMB_ENG_BITS;
                    pout_q[`CMB_PIN_SDO] <= hbyte[7];
                    pout_q[`CMB_PIN_SCK] <= 1'b0;
                    div_q <= 8'h00;
                    st_q <= ST_LOW;
                  end
                ST_LOW:
                  if (half_done)
                  begin
                    pout_q[`CMB_PIN_SCK] <= 1'b1;
                    sh_q <= {2'b00, sh_q[6:0], pins[`CMB_PIN_SDI]};
                    cnt_q <= cnt_q - 4'h1;
                    div_q <= 8'h00;
                    st_q <= adapt ? ST_WAIT : ST_HIGH;
                  end
                  else
                    div_q <= div_q + 8'h01;
                ST_WAIT:
                  if (pins[`CMB_PIN_RCK])
                  begin
                    div_q <= 8'h00;
                    st_q <= ST_HIGH;
                  end
                ST_HIGH:
                  if (half_done)
                  begin
                    pout_q[`CMB_PIN_SCK] <= 1'b0;
                    div_q <= 8'h00;
                    if (cnt_q == 4'h0)
                    begin
                      smp_q <= sh_q[7:0];
                      smp_v_q <= 1'b1;
                      st_q <= ST_IDLE;
                    end
                    else
                    begin
                      pout_q[`CMB_PIN_SDO] <= sh_q[7];
                      st_q <= ST_LOW;
                    end
                  end
                  else
                    div_q <= div_q + 8'h01;
                default: st_q <= ST_IDLE;
              endcase
            end
            default: st_q <= ST_IDLE;
          endcase
        end
      end

      // output enables are decoded from the mode, and from dir_q in the abb and sbb modes
      reg [7:0] oe_n_q;
      always @(posedge mclk)
      begin
        if (reset)
          oe_n_q <= 8'hfe;
        else
        begin
          case (mode_q)
            `CMB_MODE_UART: oe_n_q <= 8'hfe;
            `CMB_MODE_ABB: oe_n_q <= ~dir_q[gi*8 +: 8];
            `CMB_MODE_SBB: oe_n_q <= ~dir_q[gi*8 +: 8];
            `CMB_MODE_ENG: oe_n_q <= 8'hfc;
            default: oe_n_q <= 8'hff;
          endcase
        end
      end

      assign mode_vec[gi*3 +: 3] = mode_q;
      assign busy_vec[gi] = busy_q | pend_q | (st_q != ST_IDLE);
      assign txen_vec[gi] = txen_q;
      assign host_byte_ready[gi] = rdy_q;
      assign sample_valid[gi] = smp_v_q;
      assign sample_data[gi*8 +: 8] = smp_q;
      assign pin_out[gi*8 +: 8] = pout_q;
      assign pin_oe_n[gi*8 +: 8] = oe_n_q;
      assign rs485_tx_enable[gi] = txen_q;
    end
  endgenerate
endmodule // cmb_channel_mode_ctl

// [design/cmb_channel_mode_map.vh]
`ifndef CMB_CHANNEL_MODE_MAP_VH
`define CMB_CHANNEL_MODE_MAP_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CMB_OFS_CMD 8'h00
`define CMB_OFS_MODE 8'h04
`define CMB_OFS_CFG 8'h08
`define CMB_OFS_BAUD 8'h0c
`define CMB_OFS_DIR 8'h10
`define CMB_OFS_SCKDIV 8'h14
`define CMB_OFS_STATUS 8'h18

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CMB_CFG_RST 6'h00
`define CMB_BAUD_RST 16'h0001
`define CMB_DIR_RST 32'h00000000
`define CMB_SCKDIV_RST 8'h00
`define CMB_PINS_IDLE 8'hff

// ----------------------------------------------------------------
// mode codes carried by the mode-select command
// ----------------------------------------------------------------
`define CMB_MODE_UART 3'h0
`define CMB_MODE_ABB 3'h1
`define CMB_MODE_ENG 3'h2
`define CMB_MODE_SBB 3'h4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CMB_CMD_CODE 7:0
`define CMB_CMD_CHAN 9:8
`define CMB_CFG_RS485 3:0
`define CMB_CFG_ADAPT 5:4
`define CMB_PIN_TXD 0
`define CMB_PIN_SCK 0
`define CMB_PIN_SDO 1
`define CMB_PIN_SDI 2
`define CMB_PIN_RCK 7
`define CMB_ENG_CHANNELS 2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CMB_CLK_PERIOD_NS 25
`define CMB_SCK_HALF_MIN_NS 15
`define CMB_SCK_HALF_CYC ((`CMB_SCK_HALF_MIN_NS + `CMB_CLK_PERIOD_NS - 1) / `CMB_CLK_PERIOD_NS)
`define CMB_UART_BITS 4'ha
`define CMB_ENG_BITS 4'h8

`endif

// [sim/cmb_channel_mode_chk.sv]
`timescale 1ns/1ps
`include "cmb_channel_mode_map.vh"
// --------
// port checks
// --------
module cmb_channel_mode_chk (
  input logic mclk,
  input logic reset,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [3:0] host_byte_valid,
  input logic [3:0] host_byte_ready,
  input logic [3:0] sample_valid,
  input logic [31:0] sample_data,
  input logic [3:0] sample_ready,
  input logic [31:0] pin_out,
  input logic [3:0] rs485_tx_enable,
  input logic host_suspend,
  input logic power_enable_n
);
  logic cmd_wr;
  logic [7:0] quiet_q;
  assign cmd_wr = psel && penable && pready && pwrite && paddr == `CMB_OFS_CMD;
  // limit assumes a character fits in 64 cycles, so small baud divisors only
  always @(posedge mclk)
    if (reset || psel || (host_byte_valid & host_byte_ready) != 4'h0)
      quiet_q <= 8'h00;
    else if (quiet_q != 8'hff)
      quiet_q <= quiet_q + 8'h01;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  a_reset_idle: assert property ($past(reset) |->
    pin_out == 32'hffffffff && sample_valid == 4'h0) else $error("not idle after reset");
  a_power_follow: assert property (!$past(reset) |->
    power_enable_n == $past(host_suspend)) else $error("power enable lags wrong");
  a_txen_idle: assert property (
    (host_byte_ready & $past(host_byte_ready) & rs485_tx_enable) == 4'h0)
    else $error("tx enable while idle");
  a_sample_hold: assert property (sample_valid[1] && !sample_ready[1] && !cmd_wr
    |=> sample_valid[1] && $stable(sample_data[15:8])) else $error("sample lost");
  a_busy_refuse: assert property (
    (sample_valid & $past(sample_valid) & host_byte_ready) == 4'h0)
    else $error("ready while sample pending");
  a_take_drops: assert property ((host_byte_valid & host_byte_ready) != 4'h0 && !cmd_wr
    |=> (host_byte_ready & $past(host_byte_valid & host_byte_ready)) == 4'h0)
    else $error("ready kept after take");
  a_quiet_pins: assert property (quiet_q > 8'h3f |-> $stable(pin_out))
    else $error("pins moved without data");
  a_apb_wait: assert property (psel && !penable |=> ##1 pready && $past(pready) == 1'b0)
    else $error("bus answer late");
  a_err_pair: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready");
  c_pop: cover property (sample_valid[1] && sample_ready[1]);
  c_txen: cover property ($rose(rs485_tx_enable[0]));
  c_err: cover property (pslverr);
  c_quiet: cover property (quiet_q == 8'h40);
endmodule // cmb_channel_mode_chk

bind cmb_channel_mode_ctl cmb_channel_mode_chk cmb_channel_mode_chk_inst (.mclk, .reset,
  .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .host_byte_valid,
  .host_byte_ready, .sample_valid, .sample_data, .sample_ready, .pin_out,
  .rs485_tx_enable, .host_suspend, .power_enable_n);

// [sim/cmb_pin_model.sv]
`timescale 1ns/1ps
// --------
// far-side pins with levels from ext_level
// --------
module cmb_pin_model (
  input logic mclk,
  input logic [31:0] pin_out,
  input logic [31:0] pin_oe_n,
  input logic [31:0] ext_level,
  input logic [3:0] rck_delay,
  output logic [31:0] pin_in
);
  logic [15:0] sck_q;
  logic [31:0] far;
  always @(posedge mclk)
    sck_q <= {sck_q[14:0], pin_out[0]};
  always_comb
  begin
    far = ext_level;
    far[2] = pin_out[1];
    // zero delay models a target that never returns the clock
    far[7] = rck_delay == 4'h0 ? 1'b0 : sck_q[rck_delay - 4'h1];
    pin_in = far;
    for (int i = 0; i < 32; i++)
      if (!pin_oe_n[i])
        pin_in[i] = pin_out[i];
  end
endmodule // cmb_pin_model

// [sim/test_channel_mode_bitbang_ctl.sv]
`timescale 1ns/1ps
`include "cmb_channel_mode_map.vh"
module test_channel_mode_bitbang_ctl;
  logic mclk, reset, psel, penable, pwrite, pready, pslverr, host_suspend, power_enable_n, err;
  logic [7:0] paddr, s;
  logic [31:0] pwdata, prdata, host_byte_data, sample_data, pin_in, pin_out, pin_oe_n;
  logic [31:0] ext_level, rd;
  logic [3:0] host_byte_valid, host_byte_ready, sample_valid, sample_ready;
  logic [3:0] rs485_tx_enable, rck_delay;
  logic [11:0] me;
  logic [7:0] codes [6] = '{8'h01, 8'h04, 8'h02, 8'h03, 8'h07, 8'h00};
  int bad_count, samples_checked, cyc, t0, n, k;
  cmb_channel_mode_ctl cmb_channel_mode_ctl_inst (.mclk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .host_byte_valid, .host_byte_data,
    .host_byte_ready, .sample_valid, .sample_data, .sample_ready, .pin_in, .pin_out,
    .pin_oe_n, .rs485_tx_enable, .host_suspend, .power_enable_n);
  cmb_pin_model cmb_pin_model_inst (.mclk, .pin_out, .pin_oe_n, .ext_level, .rck_delay,
    .pin_in);
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 1;
  // --------
  // tasks
  // --------
  task check(input string name, input logic [31:0] exp, input logic [31:0] got);
  begin
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  end
  endtask
  task results;
  begin
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
  begin
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // no limit here: a dead slave is caught by the watchdog
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask
  task put(input int ch, input logic [7:0] b);
  begin
    @(posedge mclk);
    host_byte_valid[ch] <= 1'b1;
    host_byte_data[8*ch +: 8] <= b;
    do @(posedge mclk); while (host_byte_ready[ch] !== 1'b1);
    host_byte_valid[ch] <= 1'b0;
  end
  endtask
  task get(input int ch, output logic [7:0] v);
  begin
    @(posedge mclk);
    sample_ready[ch] <= 1'b1;
    do @(posedge mclk); while (sample_valid[ch] !== 1'b1);
    v = sample_data[8*ch +: 8];
    sample_ready[ch] <= 1'b0;
  end
  endtask
  task do_reset;
  begin
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
  end
  endtask
  // --------
  // sequence
  // --------
  initial
  begin
    mclk = 0;
    reset = 1;
    {psel, penable, pwrite, paddr, pwdata, host_suspend} = '0;
    {host_byte_valid, host_byte_data, sample_ready, rck_delay} = '0;
    ext_level = 32'hffffffff;
    do_reset;
    apb(0, `CMB_OFS_MODE, 0);
    check("mode", 0, rd);
    apb(0, `CMB_OFS_CFG, 0);
    check("cfg", 0, rd);
    apb(0, 8'h40, 0);
    check("unmapped", 1, err);
    check("power", 0, power_enable_n);
    host_suspend <= 1'b1;
    repeat (2) @(posedge mclk);
    check("power", 1, power_enable_n);
    host_suspend <= 1'b0;
    me = 12'h000;
    for (int ch = 0; ch < 4; ch++)
      for (int c = 0; c < 6; c++)
      begin
        apb(1, `CMB_OFS_CMD, {22'h0, ch[1:0], codes[c]});
        if (codes[c] inside {0, 1, 4} || (codes[c] == 2 && ch < 2))
          me[3*ch +: 3] = codes[c][2:0];
        apb(0, `CMB_OFS_MODE, 0);
        check("mode", {20'h0, me}, rd);
      end
    apb(1, `CMB_OFS_DIR, 32'h0000ff00);
    apb(1, `CMB_OFS_CMD, 32'h0104);
    put(1, 8'h55);
    fork
      put(1, 8'haa);
      begin
        repeat (20) @(posedge mclk);
        check("stall", 0, host_byte_ready[1]);
        check("pins", 8'h55, pin_out[15:8]);
        check("oe", 8'h00, pin_oe_n[15:8]);
        get(1, s);
        check("lag", 8'hff, s);
      end
    join
    get(1, s);
    check("lag", 8'h55, s);
    repeat (2) @(posedge mclk);
    check("pins", 8'haa, pin_out[15:8]);
    apb(1, `CMB_OFS_DIR, 32'h00000f00);
    ext_level[15:8] <= 8'h50;
    put(1, 8'h3c);
    get(1, s);
    check("mixed", 8'h5a, s);
    check("oe", 8'hf0, pin_oe_n[15:8]);
    apb(1, `CMB_OFS_BAUD, 4);
    apb(1, `CMB_OFS_DIR, 32'h00ff0000);
    apb(1, `CMB_OFS_CMD, 32'h0201);
    repeat (30) @(posedge mclk);
    check("hold", 8'hff, pin_out[23:16]);
    put(2, 8'h3c);
    repeat (12) @(posedge mclk);
    check("async", 8'h3c, pin_out[23:16]);
    apb(1, `CMB_OFS_CFG, 1);
    apb(0, `CMB_OFS_MODE, 0);
    check("mode", 32'h060, rd);
    put(0, 8'ha5);
    // ready still reads high in the take step, so let it drop first
    @(posedge mclk);
    n = 0;
    for (k = 0; k < 200 && host_byte_ready[0] !== 1'b1; k++)
    begin
      @(posedge mclk);
      n += rs485_tx_enable[0];
    end
    check("txen_len", 1, n >= 40 && n <= 44);
    repeat (2) @(posedge mclk);
    check("txen_off", 0, rs485_tx_enable);
    apb(1, `CMB_OFS_CFG, 0);
    apb(1, `CMB_OFS_CMD, 32'h0002);
    t0 = cyc;
    put(0, 8'h96);
    get(0, s);
    check("engine", 8'h96, s);
    t0 = cyc - t0;
    // one extra cycle per half period, sixteen halves per byte
    apb(1, `CMB_OFS_SCKDIV, 1);
    n = cyc;
    put(0, 8'h96);
    get(0, s);
    check("sck_div", t0 + 16, cyc - n);
    apb(1, `CMB_OFS_SCKDIV, 0);
    apb(1, `CMB_OFS_CFG, 32'h10);
    rck_delay <= 4'h4;
    n = cyc;
    put(0, 8'h96);
    get(0, s);
    check("adapt", 8'h96, s);
    check("adapt_wait", 1, cyc - n > t0);
    // a target that never answers must freeze the engine with the clock high
    rck_delay <= 4'h0;
    put(0, 8'h96);
    repeat (40) @(posedge mclk);
    check("rck_stall", 0, sample_valid[0]);
    check("sck_held", 1, pin_out[0]);
    do_reset;
    apb(0, `CMB_OFS_MODE, 0);
    check("mode", 0, rd);
    apb(0, `CMB_OFS_CFG, 0);
    check("cfg", 0, rd);
    results;
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    results;
  end
endmodule // test_channel_mode_bitbang_ctl
